// File: include/pstc_pkg.sv
package pstc_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_NS = 40;
	localparam int PHASE_STEP_NS = 8;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = $clog2(TICK_CYCLES);

	localparam logic [11:0] OFS_CONTROL = 12'h600;
	localparam logic [11:0] OFS_CONFIG = 12'h602;
	localparam logic [11:0] OFS_NS_LOW = 12'h604;
	localparam logic [11:0] OFS_NS_HIGH = 12'h606;
	localparam logic [11:0] OFS_SEC_LOW = 12'h608;
	localparam logic [11:0] OFS_SEC_HIGH = 12'h60A;
	localparam logic [11:0] OFS_PHASE = 12'h60C;
	localparam logic [11:0] OFS_SUBNS_LOW = 12'h614;
	localparam logic [11:0] OFS_SUBNS_HIGH = 12'h616;

	localparam int CTL_LOAD_BIT = 0;
	localparam int CTL_SNAPSHOT_BIT = 1;
	localparam int CTL_STEP_BIT = 2;
	localparam int CTL_DIR_BIT = 3;
	localparam int CFG_P2P_BIT = 0;
	localparam int CFG_MASTER_BIT = 1;
	localparam int CFG_ONESTEP_BIT = 2;

	localparam logic [29:0] NS_WRAP = 30'h3B9ACA00;
	localparam logic [5:0] NS_INC_SLOW = 6'h27;
	localparam logic [5:0] NS_INC_NOM = 6'h28;
	localparam logic [5:0] NS_INC_FAST = 6'h29;

	localparam logic [31:0] SEC_RESET = 32'h00000000;
	localparam logic [29:0] NS_RESET = 30'h00000000;
	localparam logic [31:0] SUBNS_RESET = 32'h00000000;
	localparam logic [2:0] PHASE_RESET = 3'h0;
	localparam logic [2:0] CFG_RESET = 3'h0;

	localparam logic [3:0] MSG_SYNC = 4'h0;
	localparam logic [3:0] MSG_DELAY_REQ = 4'h1;
	localparam logic [3:0] MSG_PDELAY_REQ = 4'h2;
	localparam logic [3:0] MSG_PDELAY_RESP = 4'h3;
endpackage

// File: design/pstc_system_time.sv
`timescale 1ns/100ps
// Functional notes
// (R01) Seconds, nanoseconds, fraction counters, all software accessible
// (R02) Time updates once every 40ns
// (R03) Nanoseconds advance 39, 40 or 41
// (R04) Three-bit phase marks five 8ns sub-phases
// (R05) Nanoseconds wrap at one billion
// (R06) Nanosecond wrap increments seconds
// (R07) Fraction overflow carries into nanoseconds
// (R08) Seconds only 32 bits; software handles wrap
// (R09) Seconds or nanoseconds write clears phase
// (R10) Phase restarts each interval, steps every 8ns
// (R11) Write time registers, then load bit
// (R12) Snapshot bit freezes time for reads
// (R13) Software adds phase to snapshot time
// (R14) Step adds or subtracts nanoseconds, self-clears
// (R15) Network port E2E/P2P, host master/slave
// (R16) Timestamps only for the four event messages
// (R17) One-step or two-step Sync operation
module pstc_system_time #(
	parameter logic [31:0] SUBNS_STEP = 32'h00000000,
	parameter logic SUBNS_DOWN = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData,
	output logic regRdValid,
	input wire logic tsIngress,
	input wire logic tsEgress,
	input wire logic [3:0] tsMsgType,
	output logic [31:0] tsSec,
	output logic [29:0] tsNs,
	output logic [2:0] tsPhase,
	output logic tsIsEgress,
	output logic tsValid,
	output logic followUpNeeded,
	output logic p2pMode,
	output logic hostMaster,
	output logic oneStepMode,
	output logic [31:0] timeSec,
	output logic [29:0] timeNs,
	output logic [2:0] timePhase
);
	import pstc_pkg::*;

	// Cycle slot within the 40ns interval maps to the 8ns sub-phase
	function automatic logic [2:0] phaseOf(input logic [CNT_W-1:0] cnt);
		logic [CNT_W+2:0] scaled;
		scaled = {3'h0, cnt} * (CNT_W + 3)'(CLK_PERIOD_NS);
		phaseOf = 3'(scaled / (CNT_W + 3)'(PHASE_STEP_NS));
	endfunction

	// First slot that already lies in the requested sub-phase
	function automatic logic [CNT_W-1:0] slotOf(input logic [2:0] ph);
		logic [CNT_W+2:0] scaled;
		scaled = {{CNT_W{1'b0}}, ph} * (CNT_W + 3)'(PHASE_STEP_NS);
		slotOf = CNT_W'((scaled + (CNT_W + 3)'(CLK_PERIOD_NS - 1))
			/ (CNT_W + 3)'(CLK_PERIOD_NS));
	endfunction

	function automatic logic isEventMsg(input logic [3:0] t);
		isEventMsg = (t == MSG_SYNC) || (t == MSG_DELAY_REQ) ||
			(t == MSG_PDELAY_REQ) || (t == MSG_PDELAY_RESP);
	endfunction

	logic [31:0] sec_q, sec_d;
	logic [29:0] ns_q, ns_d;
	logic [31:0] subNs_q, subNs_d;
	logic [CNT_W-1:0] tickCnt_q, tickCnt_d;
	logic [31:0] setSec_q;
	logic [29:0] setNs_q;
	logic [2:0] setPhase_q;
	logic [31:0] snapSec_q;
	logic [29:0] snapNs_q;
	logic [2:0] snapPhase_q;
	logic stepPend_q, stepDir_q;
	logic [2:0] cfg_q;

	wire logic wrCtl = regWr && (regAddr == OFS_CONTROL);
	wire logic wrCfg = regWr && (regAddr == OFS_CONFIG);
	wire logic wrNsLo = regWr && (regAddr == OFS_NS_LOW);
	wire logic wrNsHi = regWr && (regAddr == OFS_NS_HIGH);
	wire logic wrSecLo = regWr && (regAddr == OFS_SEC_LOW);
	wire logic wrSecHi = regWr && (regAddr == OFS_SEC_HIGH);
	wire logic wrPhase = regWr && (regAddr == OFS_PHASE);
	wire logic wrSubLo = regWr && (regAddr == OFS_SUBNS_LOW);
	wire logic wrSubHi = regWr && (regAddr == OFS_SUBNS_HIGH);
	wire logic wrTime = wrNsLo || wrNsHi || wrSecLo || wrSecHi;
	wire logic loadNow = wrCtl && regWrData[CTL_LOAD_BIT];
	wire logic snapNow = wrCtl && regWrData[CTL_SNAPSHOT_BIT];
	wire logic stepReq = wrCtl && regWrData[CTL_STEP_BIT];
	wire logic tickNow = (tickCnt_q == CNT_W'(TICK_CYCLES - 1));
	wire logic [2:0] livePhase = phaseOf(tickCnt_q);

	// Fraction accumulator; a carry or borrow bends the nominal step
	wire logic [32:0] subSum = SUBNS_DOWN ? ({1'b0, subNs_q} - {1'b0, SUBNS_STEP})
		: ({1'b0, subNs_q} + {1'b0, SUBNS_STEP});
	wire logic subCarry = subSum[32];
	wire logic [5:0] nsInc = !subCarry ? NS_INC_NOM : (SUBNS_DOWN ? NS_INC_SLOW : NS_INC_FAST);
	wire logic [30:0] nsAdd = {1'b0, ns_q} + {25'h0, nsInc};
	wire logic tickWrap = nsAdd >= {1'b0, NS_WRAP};
	wire logic [30:0] nsTick = tickWrap ? (nsAdd - {1'b0, NS_WRAP}) : nsAdd;

	// Step amount assumed below one second so a single wrap suffices
	wire logic [30:0] stepSum = {1'b0, ns_q} + {1'b0, setNs_q};
	wire logic stepOver = stepSum >= {1'b0, NS_WRAP};
	wire logic stepUnder = ns_q < setNs_q;
	wire logic [30:0] stepAddNs = stepOver ? (stepSum - {1'b0, NS_WRAP}) : stepSum;
	wire logic [30:0] stepSubNs = stepUnder ? ({1'b0, ns_q} + {1'b0, NS_WRAP} - {1'b0, setNs_q})
		: ({1'b0, ns_q} - {1'b0, setNs_q});
	// Step waits off the tick slot so both never collide on the counters
	wire logic stepApply = stepPend_q && !tickNow && !loadNow;

	always_comb begin
		sec_d = sec_q;
		ns_d = ns_q;
		subNs_d = subNs_q;
		tickCnt_d = tickNow ? CNT_W'(0) : CNT_W'(tickCnt_q + CNT_W'(1)); // [R10]
		if (loadNow) begin
			sec_d = setSec_q; // [R11]
			ns_d = setNs_q; // [R11]
			tickCnt_d = slotOf(setPhase_q); // [R11]
		end else if (tickNow) begin
			subNs_d = subSum[31:0]; // [R07]
			ns_d = nsTick[29:0]; // [R02] [R03] [R05]
			if (tickWrap) begin
				sec_d = sec_q + 32'h00000001; // [R06] [R08]
			end
		end else if (stepApply) begin
			if (stepDir_q) begin
				ns_d = stepAddNs[29:0]; // [R14]
				sec_d = stepOver ? sec_q + 32'h00000001 : sec_q;
			end else begin
				ns_d = stepSubNs[29:0]; // [R14]
				sec_d = stepUnder ? sec_q - 32'h00000001 : sec_q;
			end
		end
		if (wrSubLo) begin
			subNs_d = {subNs_q[31:16], regWrData}; // [R01]
		end
		if (wrSubHi) begin
			subNs_d = {regWrData, subNs_q[15:0]}; // [R01]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_q <= SEC_RESET;
			ns_q <= NS_RESET;
			subNs_q <= SUBNS_RESET;
			tickCnt_q <= '0;
		end else begin
			sec_q <= sec_d;
			ns_q <= ns_d;
			subNs_q <= subNs_d;
			tickCnt_q <= tickCnt_d;
		end
	end

	// Staging registers hold software values for load and step
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setSec_q <= SEC_RESET;
			setNs_q <= NS_RESET;
			setPhase_q <= PHASE_RESET;
		end else begin
			if (wrNsLo) setNs_q[15:0] <= regWrData; // [R01]
			if (wrNsHi) setNs_q[29:16] <= regWrData[13:0]; // [R01]
			if (wrSecLo) setSec_q[15:0] <= regWrData; // [R01]
			if (wrSecHi) setSec_q[31:16] <= regWrData; // [R01]
			if (wrPhase) setPhase_q <= regWrData[2:0];
			else if (wrTime) setPhase_q <= PHASE_RESET; // [R09]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			snapSec_q <= SEC_RESET;
			snapNs_q <= NS_RESET;
			snapPhase_q <= PHASE_RESET;
		end else if (snapNow) begin
			snapSec_q <= sec_q; // [R12]
			snapNs_q <= ns_q; // [R12]
			snapPhase_q <= livePhase; // [R12] [R13]
		end
	end

	// A new request while one is pending wins over the self-clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stepPend_q <= 1'b0;
			stepDir_q <= 1'b0;
			cfg_q <= CFG_RESET;
		end else begin
			if (stepReq) begin
				stepPend_q <= 1'b1;
				stepDir_q <= regWrData[CTL_DIR_BIT];
			end else if (stepApply) begin
				stepPend_q <= 1'b0; // [R14]
			end
			if (wrCfg) cfg_q <= regWrData[2:0]; // [R15]
		end
	end

	logic [15:0] rdMux;
	always_comb begin
		rdMux = 16'h0000;
		if (regAddr == OFS_CONTROL) rdMux = {12'h000, stepDir_q, stepPend_q, 2'b00};
		else if (regAddr == OFS_CONFIG) rdMux = {13'h0000, cfg_q};
		else if (regAddr == OFS_NS_LOW) rdMux = snapNs_q[15:0]; // [R12]
		else if (regAddr == OFS_NS_HIGH) rdMux = {2'b00, snapNs_q[29:16]};
		else if (regAddr == OFS_SEC_LOW) rdMux = snapSec_q[15:0];
		else if (regAddr == OFS_SEC_HIGH) rdMux = snapSec_q[31:16];
		else if (regAddr == OFS_PHASE) rdMux = {13'h0000, snapPhase_q};
		else if (regAddr == OFS_SUBNS_LOW) rdMux = subNs_q[15:0];
		else if (regAddr == OFS_SUBNS_HIGH) rdMux = subNs_q[31:16];
	end

	wire logic evtSeen = (tsIngress || tsEgress) && isEventMsg(tsMsgType); // [R16]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 16'h0000;
			regRdValid <= 1'b0;
			tsSec <= SEC_RESET;
			tsNs <= NS_RESET;
			tsPhase <= PHASE_RESET;
			tsIsEgress <= 1'b0;
			tsValid <= 1'b0;
			followUpNeeded <= 1'b0;
		end else begin
			regRdValid <= regRd;
			if (regRd) regRdData <= rdMux;
			tsValid <= evtSeen; // [R16]
			followUpNeeded <= tsEgress && (tsMsgType == MSG_SYNC) &&
				!cfg_q[CFG_ONESTEP_BIT]; // [R17]
			if (evtSeen) begin
				tsSec <= sec_q;
				tsNs <= ns_q;
				tsPhase <= livePhase;
				tsIsEgress <= tsEgress;
			end
		end
	end

	assign p2pMode = cfg_q[CFG_P2P_BIT]; // [R15]
	assign hostMaster = cfg_q[CFG_MASTER_BIT]; // [R15]
	assign oneStepMode = cfg_q[CFG_ONESTEP_BIT]; // [R17]
	assign timeSec = sec_q;
	assign timeNs = ns_q;
	assign timePhase = livePhase; // [R04]

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence seqQuietInterval;
		tickNow && !loadNow ##1 (!loadNow)[*7];
	endsequence

	sequence seqStepIssued;
		stepReq && !stepPend_q;
	endsequence

	sequence seqSnapHeld;
		snapNow ##1 (!snapNow)[*3];
	endsequence

	// Whole time in ns; a step must move it by exactly the staged amount
	wire logic [63:0] totalNs = {32'h00000000, sec_q} * 64'(NS_WRAP)
		+ {34'h000000000, ns_q};

	AST_TICK_PERIOD: assert property (seqQuietInterval |-> ##1 tickNow) // [R02]
		else $error("tick not eight cycles apart");
	AST_NS_STEP: assert property (tickNow && !loadNow && !$past(loadNow) && !tickWrap |=>
		(ns_q - $past(ns_q) >= 30'h27) && (ns_q - $past(ns_q) <= 30'h29)) // [R03]
		else $error("nanoseconds step out of range");
	AST_NS_BOUND: assert property (ns_q < NS_WRAP) // [R05]
		else $error("nanoseconds reached wrap value");
	AST_SEC_CARRY: assert property (tickNow && !loadNow && tickWrap |=>
		sec_q == $past(sec_q) + 32'h00000001) // [R06]
		else $error("seconds missed nanosecond wrap");
	AST_PHASE_RESTART: assert property (tickNow && !loadNow |=> timePhase == 3'h0) // [R10]
		else $error("phase did not restart");
	// A load inside the interval moves the slot, so only quiet intervals count
	AST_PHASE_CLIMB: assert property (seqQuietInterval |-> ##1 timePhase == 3'h4) // [R10]
		else $error("phase did not climb to last sub-phase");
	AST_PHASE_CLEAR: assert property (wrTime && !wrPhase |=> setPhase_q == PHASE_RESET) // [R09]
		else $error("phase not cleared by time write");
	AST_LOAD: assert property (loadNow |=> ns_q == $past(setNs_q) && sec_q == $past(setSec_q)) // [R11]
		else $error("load did not take staged time");
	AST_SNAPSHOT: assert property (seqSnapHeld |-> snapNs_q == $past(ns_q, 3)) // [R12]
		else $error("snapshot not held");
	AST_STEP_CLEAR: assert property (seqStepIssued |=> stepPend_q ##[1:3] !stepPend_q) // [R14]
		else $error("step bit did not self clear");
	AST_EVENT_TS: assert property (tsIngress && !isEventMsg(tsMsgType) && !tsEgress |=> !tsValid) // [R16]
		else $error("general message timestamped");
	AST_FOLLOWUP: assert property (followUpNeeded |-> $past(tsEgress) && !$past(oneStepMode)) // [R17]
		else $error("follow up flagged in one-step mode");

	AST_SEC_HOLD: assert property (tickNow && !loadNow && !tickWrap |=> // [R06]
		sec_q == $past(sec_q))
		else $error("seconds moved without nanosecond wrap");
	AST_NS_WRAP_LOW: assert property (tickNow && !loadNow && tickWrap |=> // [R05]
		ns_q <= 30'h29)
		else $error("nanoseconds not restarted near zero");
	AST_FRAC_STEP: assert property (tickNow && !loadNow && !wrSubLo && !wrSubHi |=> // [R07]
		subNs_q == (SUBNS_DOWN ? $past(subNs_q) - SUBNS_STEP
			: $past(subNs_q) + SUBNS_STEP))
		else $error("fraction did not take its step");
	AST_FRAC_HOLD: assert property (!tickNow && !wrSubLo && !wrSubHi |=> // [R07]
		$stable(subNs_q))
		else $error("fraction moved between ticks");
	AST_NS_IDLE: assert property (!tickNow && !loadNow && !stepApply |=> // [R02]
		$stable(ns_q) && $stable(sec_q))
		else $error("time moved between ticks");

	// Staged phases above four have no slot and are left out
	AST_LOAD_PHASE: assert property (loadNow && setPhase_q <= 3'h4 |=> // [R11]
		timePhase == $past(setPhase_q))
		else $error("load did not take staged phase");
	AST_SNAP_SEC: assert property (snapNow |=> // [R12]
		snapSec_q == $past(sec_q))
		else $error("snapshot seconds wrong");
	AST_SNAP_PHASE: assert property (snapNow |=> // [R12]
		snapPhase_q == $past(timePhase))
		else $error("snapshot phase wrong");

	AST_STEP_ADD: assert property (stepApply && stepDir_q |=> // [R14]
		totalNs == $past(totalNs) + 64'($past(setNs_q)))
		else $error("step add gave wrong time");
	AST_STEP_SUB: assert property (stepApply && !stepDir_q |=> // [R14]
		totalNs == $past(totalNs) - 64'($past(setNs_q)))
		else $error("step subtract gave wrong time");
	AST_TS_TIME: assert property (evtSeen |=> // [R16]
		tsNs == $past(ns_q) && tsSec == $past(sec_q)
			&& tsPhase == $past(timePhase))
		else $error("timestamp not taken at strobe");
	AST_CFG_PORTS: assert property (wrCfg |=> // [R15]
		{oneStepMode, hostMaster, p2pMode} == $past(regWrData[2:0]))
		else $error("port roles not taken from config write");
endmodule

// File: sim/pstc_tb.sv
`timescale 1ns/100ps
`define CHK(n,e,g) begin nChecks++; if ((g)!==(e)) begin errors++; $display("Error %s exp %0h got %0h",n,(e),(g)); end end
module testbench;
	import pstc_pkg::*;
	logic clk = 0, rst_n = 0, regWr = 0, regRd = 0, tsIngress = 0, tsEgress = 0;
	logic [11:0] regAddr = '0;
	logic [15:0] regWrData = '0;
	logic [3:0] tsMsgType = '0;
	logic [15:0] regRdData;
	logic regRdValid, tsIsEgress, tsValid, followUpNeeded, p2pMode, hostMaster, oneStepMode;
	logic [31:0] tsSec, timeSec;
	logic [29:0] tsNs, timeNs;
	logic [2:0] tsPhase, timePhase;
	int errors = 0, nChecks = 0, cyc = 0;
	// Quarter-ns fraction step: a carry every fourth tick
	pstc_system_time #(.SUBNS_STEP(32'h40000000), .SUBNS_DOWN(1'b0)) u_dut (.clk, .rst_n,
		.regAddr, .regWr, .regRd, .regWrData, .regRdData, .regRdValid, .tsIngress,
		.tsEgress, .tsMsgType, .tsSec, .tsNs, .tsPhase, .tsIsEgress, .tsValid,
		.followUpNeeded, .p2pMode, .hostMaster, .oneStepMode, .timeSec, .timeNs, .timePhase);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			errors++;
			print_verdict;
		end
	end
	task print_verdict;
		$display("checks %0d errors %0d", nChecks, errors);
		if (errors == 0 && nChecks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task tk;
		@(posedge clk);
		#1;
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		regAddr = a;
		regWrData = d;
		regWr = 1;
		tk;
		regWr = 0;
	endtask
	task rd(input logic [11:0] a, output logic [15:0] d);
		regAddr = a;
		regRd = 1;
		tk;
		regRd = 0;
		`CHK("rdValid", 1'b1, regRdValid)
		d = regRdData;
	endtask
	task setTime(input logic [31:0] s, input logic [29:0] n, input logic [2:0] p);
		wr(OFS_SEC_LOW, s[15:0]);
		wr(OFS_SEC_HIGH, s[31:16]);
		wr(OFS_NS_LOW, n[15:0]);
		wr(OFS_NS_HIGH, {2'h0, n[29:16]});
		wr(OFS_PHASE, {13'h0, p});
		wr(OFS_CONTROL, 16'h0001);
	endtask
	task t_rate;
		logic [29:0] a;
		`CHK("secRst", 32'h0, timeSec)
		a = timeNs;
		// Any 64 cycles hold 8 ticks and exactly 2 carries
		repeat (64) tk;
		`CHK("ns8", 30'(a + 30'd322), timeNs)
	endtask
	task t_wrap;
		setTime(32'hFFFFFFFF, NS_WRAP - 30'd16, 3'h0);
		`CHK("ldSec", 32'hFFFFFFFF, timeSec)
		for (int s = 0; s < 8; s++) begin
			`CHK("phase", 3'((5 * s) / 8), timePhase)
			tk;
		end
		`CHK("phaseRestart", 3'h0, timePhase)
		`CHK("secWrap", 32'h0, timeSec)
		`CHK("nsWrap", 1'b1, timeNs inside {30'd24, 30'd25})
	endtask
	task t_phase;
		setTime(32'h5, 30'd100, 3'h3);
		`CHK("ldPhase", 3'h3, timePhase)
		wr(OFS_PHASE, 16'h0003);
		wr(OFS_NS_LOW, 16'h0064);
		wr(OFS_CONTROL, 16'h0001);
		`CHK("phaseClr", 3'h0, timePhase)
	endtask
	task t_snap;
		logic [29:0] n;
		logic [31:0] s;
		logic [15:0] a, b, c, d, e, f;
		logic [2:0] p;
		regAddr = OFS_CONTROL;
		regWrData = 16'h0002;
		regWr = 1;
		n = timeNs;
		p = timePhase;
		s = timeSec;
		tk;
		regWr = 0;
		repeat (20) tk;
		rd(OFS_NS_LOW, a);
		rd(OFS_NS_HIGH, b);
		rd(OFS_SEC_LOW, c);
		rd(OFS_SEC_HIGH, d);
		`CHK("snapSec", s, {d, c})
		`CHK("snapNs", 1'b1, 30'({b[13:0], a} - n) <= 30'd41)
		rd(OFS_NS_LOW, e);
		`CHK("snapHeld", a, e)
		rd(OFS_PHASE, f);
		`CHK("snapPhase", p, f[2:0])
		`CHK("exactNs", 30'(n + 30'(8 * p)), 30'({b[13:0], a} + 30'(8 * f[2:0])))
	endtask
	task t_step;
		logic [15:0] r;
		logic [29:0] x;
		for (int dir = 0; dir < 2; dir++) begin
			setTime(32'h7, 30'd500000, 3'h0);
			wr(OFS_NS_LOW, 16'h03E8);
			wr(OFS_NS_HIGH, 16'h0000);
			wr(OFS_CONTROL, 16'(4 + 8 * dir));
			// Mid-interval sample: one tick passed, carry may add one
			repeat (9) tk;
			x = dir ? 30'd501040 : 30'd499040;
			`CHK("step", 1'b1, 30'(timeNs - x) <= 30'd1)
			rd(OFS_CONTROL, r);
			`CHK("stepClr", 1'b0, r[CTL_STEP_BIT])
		end
	endtask
	task t_cfg;
		for (int i = 0; i < 8; i++) begin
			wr(OFS_CONFIG, 16'(i));
			`CHK("cfg", 3'(i), {oneStepMode, hostMaster, p2pMode})
		end
	endtask
	task t_ts;
		logic [29:0] n;
		logic [31:0] s;
		logic [2:0] p;
		for (int os = 0; os < 2; os++) begin
			wr(OFS_CONFIG, 16'(4 * os));
			for (int t = 0; t < 6; t++) begin
				for (int e = 0; e < 2; e++) begin
					tsMsgType = 4'(t);
					tsEgress = 1'(e);
					tsIngress = 1'(!e);
					n = timeNs;
					s = timeSec;
					p = timePhase;
					tk;
					`CHK("tsValid", t < 4, tsValid)
					`CHK("followUp", e == 1 && t == 0 && os == 0, followUpNeeded)
					if (t < 4) begin
						`CHK("tsNs", n, tsNs)
						`CHK("tsSec", s, tsSec)
						`CHK("tsPhase", p, tsPhase)
						`CHK("tsEgress", 1'(e), tsIsEgress)
					end
				end
			end
			tsEgress = 0;
			tsIngress = 0;
			tk;
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1;
		t_rate;
		t_wrap;
		t_phase;
		t_snap;
		t_step;
		t_cfg;
		t_ts;
		print_verdict;
	end
endmodule
